// file: common/two_wire_pkg.sv
// Constants and types shared by the two-wire slave engine.
// Assumes an APB master on pclk at 40 MHz and an external bus master driving the serial clock.
package two_wire_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] control_command_offset   = 12'h000;
    localparam logic [11:0] slave_mode_offset        = 12'h008;
    localparam logic [11:0] clock_waveform_offset    = 12'h010;
    localparam logic [11:0] status_offset            = 12'h020;
    localparam logic [11:0] receive_holding_offset   = 12'h030;
    localparam logic [11:0] transmit_holding_offset  = 12'h034;

    // ------------------------------------------------------------
    // Field positions, general call address and phase encoding
    // ------------------------------------------------------------
    localparam int master_disable_bit = 3;
    localparam int slave_enable_bit   = 4;
    localparam int slave_disable_bit  = 5;
    localparam int soft_reset_bit     = 7;
    localparam int address_lsb        = 16;
    localparam int transfer_complete_bit = 0;
    localparam int receive_ready_bit  = 1;
    localparam int transmit_ready_bit = 2;
    localparam int direction_bit      = 3;
    localparam int access_bit         = 4;
    localparam int general_call_bit   = 5;
    localparam int nack_bit           = 8;
    localparam int clock_wait_bit     = 10;
    localparam int end_access_bit     = 11;
    localparam logic [6:0] general_call_address = 7'h00;

    typedef enum logic [5:0] {
        st_idle    = 6'h01,
        st_address = 6'h02,
        st_tx      = 6'h04,
        st_rx      = 6'h08,
        st_ack     = 6'h10,
        st_ignore  = 6'h20
    } phase_type;

endpackage

// file: hw/two_wire_slave_engine.sv
// Slave engine of the two-wire unit with an APB register slave.
// Assumes serial clock and data arrive asynchronously and are sampled by pclk.
//
// Design decisions made here: the APB register port and the address map.
module two_wire_slave_engine (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe
);

    typedef struct packed {
        logic [1:0]  scl_sync;
        logic [1:0]  sda_sync;
        logic        scl_prev;
        logic        sda_prev;
        two_wire_pkg::phase_type phase;
        two_wire_pkg::phase_type after_ack;
        logic [3:0]  bit_count;
        logic [7:0]  shift;
        logic        shift_full;
        logic [6:0]  own_slave_address;
        logic        slave_enabled;
        logic [31:0] clock_waveform_settings;
        logic [7:0]  transmit_holding_reg;
        logic [7:0]  receive_holding_reg;
        logic        transfer_complete_flag;
        logic        receive_ready_flag;
        logic        transmit_ready_flag;
        logic        slave_direction_flag;
        logic        slave_access_flag;
        logic        general_call_flag;
        logic        nack_flag;
        logic        end_of_access_flag;
        logic        sda_low;
        logic        stretch;
        logic        gc_window;
        logic [31:0] prdata;
    } state_type;

    state_type state_reg;
    state_type state_next;

    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic wr_access;
    logic rd_access;

    // ------------------------------------------------------------
    // Bus event decoding
    // ------------------------------------------------------------
    // Only the second synchroniser stage feeds the edge detectors.
    assign scl        = state_reg.scl_sync[1];
    assign sda        = state_reg.sda_sync[1];
    assign scl_rise   = scl & ~state_reg.scl_prev;
    assign scl_fall   = ~scl & state_reg.scl_prev;
    assign start_seen = scl & state_reg.scl_prev & ~sda & state_reg.sda_prev;
    assign stop_seen  = scl & state_reg.scl_prev & sda & ~state_reg.sda_prev;
    assign wr_access  = psel & penable & pwrite;
    assign rd_access  = psel & penable & ~pwrite;

    // Outputs; the APB slave always answers with zero wait states.
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign prdata  = state_reg.prdata;
    assign scl_out = 1'b0;
    assign scl_oe  = state_reg.stretch;
    assign sda_out = 1'b0;
    assign sda_oe  = state_reg.sda_low;

    // Next-state logic for serial engine and register file.
    always_comb begin
        state_next = state_reg;
        state_next.scl_sync = {state_reg.scl_sync[0], scl_in};
        state_next.sda_sync = {state_reg.sda_sync[0], sda_in};
        state_next.scl_prev = scl;
        state_next.sda_prev = sda;

        // --------------------------------------------------------
        // Serial engine
        // --------------------------------------------------------
        if (!state_reg.slave_enabled) begin
            state_next.phase   = two_wire_pkg::st_idle;
            state_next.sda_low = 1'b0;
            state_next.stretch = 1'b0;
        end else if (start_seen) begin
            if (state_reg.slave_access_flag) begin
                state_next.end_of_access_flag = 1'b1;
            end
            state_next.phase     = two_wire_pkg::st_address;
            state_next.bit_count = 4'h0;
            state_next.sda_low   = 1'b0;
            state_next.stretch   = 1'b0;
        end else if (stop_seen) begin
            if (state_reg.slave_access_flag) begin
                state_next.end_of_access_flag     = 1'b1;
                state_next.transfer_complete_flag = 1'b1;
            end
            state_next.slave_access_flag = 1'b0;
            state_next.phase   = two_wire_pkg::st_idle;
            state_next.sda_low = 1'b0;
            state_next.stretch = 1'b0;
        end else begin
            case (state_reg.phase)
                two_wire_pkg::st_address: begin
                    if (scl_rise) begin
                        state_next.shift     = {state_reg.shift[6:0], sda};
                        state_next.bit_count = state_reg.bit_count + 4'h1;
                    end
                    if (scl_fall && state_reg.bit_count == 4'h8) begin
                        if (state_reg.shift[7:1] == state_reg.own_slave_address ||
                            state_reg.shift[7:1] == two_wire_pkg::general_call_address) begin
                            state_next.slave_access_flag    = 1'b1;
                            state_next.slave_direction_flag = state_reg.shift[0];
                            if (state_reg.shift[7:1] == two_wire_pkg::general_call_address) begin
                                state_next.general_call_flag = 1'b1;
                                state_next.gc_window         = 1'b1;
                            end
                            state_next.sda_low   = 1'b1;
                            state_next.phase     = two_wire_pkg::st_ack;
                            state_next.after_ack = state_reg.shift[0] ? two_wire_pkg::st_tx
                                                                     : two_wire_pkg::st_rx;
                        end else begin
                            if (state_reg.slave_access_flag) begin
                                state_next.transfer_complete_flag = 1'b1;
                            end
                            state_next.slave_access_flag = 1'b0;
                            state_next.phase = two_wire_pkg::st_ignore;
                        end
                    end
                end
                two_wire_pkg::st_ack: begin
                    // A count of nine marks that the acknowledge clock has already fallen.
                    if (scl_fall) begin
                        state_next.bit_count = 4'h9;
                    end
                    if (state_reg.after_ack == two_wire_pkg::st_tx && state_reg.transmit_ready_flag
                        && !state_reg.shift_full) begin
                        state_next.stretch = ~scl;
                    end else if (state_reg.after_ack == two_wire_pkg::st_tx && !state_reg.shift_full) begin
                        state_next.shift      = state_reg.transmit_holding_reg;
                        state_next.shift_full = 1'b1;
                    end else if (scl_fall || (!scl && state_reg.bit_count == 4'h9)) begin
                        state_next.stretch   = 1'b0;
                        state_next.bit_count = 4'h0;
                        state_next.phase     = state_reg.after_ack;
                        state_next.sda_low   = (state_reg.after_ack == two_wire_pkg::st_tx)
                                               ? ~state_reg.shift[7] : 1'b0;
                    end else begin
                        state_next.stretch = 1'b0;
                    end
                end
                two_wire_pkg::st_tx: begin
                    if (scl_fall) begin
                        state_next.bit_count = state_reg.bit_count + 4'h1;
                        state_next.shift     = {state_reg.shift[6:0], 1'b1};
                        state_next.sda_low   = (state_reg.bit_count < 4'h7) ? ~state_reg.shift[6] : 1'b0;
                    end
                    if (scl_rise && state_reg.bit_count == 4'h8) begin
                        state_next.shift_full          = 1'b0;
                        state_next.transmit_ready_flag = 1'b1;
                        if (sda) begin
                            state_next.nack_flag = 1'b1;
                            state_next.phase     = two_wire_pkg::st_ignore;
                        end else begin
                            state_next.phase     = two_wire_pkg::st_ack;
                            state_next.after_ack = two_wire_pkg::st_tx;
                        end
                    end
                end
                two_wire_pkg::st_rx: begin
                    if (scl_rise && state_reg.bit_count < 4'h8) begin
                        state_next.shift     = {state_reg.shift[6:0], sda};
                        state_next.bit_count = state_reg.bit_count + 4'h1;
                    end
                    if (scl_fall && state_reg.bit_count == 4'h8) begin
                        state_next.shift_full = 1'b1;
                    end
                    if (state_reg.shift_full) begin
                        if (!state_reg.receive_ready_flag) begin
                            state_next.receive_holding_reg = state_reg.shift;
                            state_next.receive_ready_flag  = 1'b1;
                            state_next.shift_full          = 1'b0;
                            state_next.sda_low             = 1'b1;
                            state_next.stretch             = 1'b0;
                            state_next.phase     = two_wire_pkg::st_ack;
                            state_next.after_ack = two_wire_pkg::st_rx;
                        end else begin
                            state_next.stretch = 1'b1;
                        end
                    end
                end
                default: begin
                    state_next.sda_low = 1'b0;
                    state_next.stretch = 1'b0;
                end
            endcase
        end

        // --------------------------------------------------------
        // Register file
        // --------------------------------------------------------
        // waveform settings kept, never used
        if (wr_access) begin
            if (paddr == two_wire_pkg::control_command_offset) begin
                if (pwdata[two_wire_pkg::soft_reset_bit]) begin
                    state_next = '0;
                    state_next.transfer_complete_flag = 1'b1;
                    state_next.transmit_ready_flag    = 1'b1;
                    state_next.phase     = two_wire_pkg::st_idle;
                    state_next.after_ack = two_wire_pkg::st_idle;
                end else if (pwdata[two_wire_pkg::slave_disable_bit]) begin
                    state_next.slave_enabled = 1'b0;
                end else if (pwdata[two_wire_pkg::slave_enable_bit]) begin
                    state_next.slave_enabled = 1'b1;
                end
            end else if (paddr == two_wire_pkg::slave_mode_offset) begin
                if (!state_reg.slave_enabled || state_reg.gc_window) begin
                    state_next.own_slave_address = pwdata[two_wire_pkg::address_lsb +: 7];
                    state_next.gc_window         = 1'b0;
                end
            end else if (paddr == two_wire_pkg::clock_waveform_offset) begin
                state_next.clock_waveform_settings = pwdata;
            end else if (paddr == two_wire_pkg::transmit_holding_offset) begin
                state_next.transmit_holding_reg = pwdata[7:0];
                state_next.transmit_ready_flag  = 1'b0;
            end
        end else if (rd_access) begin
            if (paddr == two_wire_pkg::status_offset) begin
                // Read-clear flags; a set in this cycle wins over the clear.
                state_next.general_call_flag  = state_next.general_call_flag & ~state_reg.general_call_flag;
                state_next.nack_flag          = state_next.nack_flag & ~state_reg.nack_flag;
                state_next.end_of_access_flag = state_next.end_of_access_flag & ~state_reg.end_of_access_flag;
            end else if (paddr == two_wire_pkg::receive_holding_offset) begin
                if (!(state_next.receive_ready_flag && !state_reg.receive_ready_flag)) begin
                    state_next.receive_ready_flag = 1'b0;
                end
            end
        end
        if (state_next.slave_access_flag && !state_reg.slave_access_flag) begin
            state_next.transfer_complete_flag = 1'b0;
        end
        // Read data is captured at the setup edge, so it stands in the access cycle.
        state_next.prdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            if (paddr == two_wire_pkg::status_offset) begin
                state_next.prdata[two_wire_pkg::transfer_complete_bit] = state_next.transfer_complete_flag;
                state_next.prdata[two_wire_pkg::receive_ready_bit]     = state_next.receive_ready_flag;
                state_next.prdata[two_wire_pkg::transmit_ready_bit]    = state_next.transmit_ready_flag;
                state_next.prdata[two_wire_pkg::direction_bit]  = state_next.slave_direction_flag;
                state_next.prdata[two_wire_pkg::access_bit]     = state_next.slave_access_flag;
                state_next.prdata[two_wire_pkg::general_call_bit] = state_next.general_call_flag;
                state_next.prdata[two_wire_pkg::nack_bit]       = state_next.nack_flag;
                state_next.prdata[two_wire_pkg::clock_wait_bit] = state_next.stretch;
                state_next.prdata[two_wire_pkg::end_access_bit] = state_next.end_of_access_flag;
            end else if (paddr == two_wire_pkg::slave_mode_offset) begin
                state_next.prdata[two_wire_pkg::address_lsb +: 7] = state_next.own_slave_address;
            end else if (paddr == two_wire_pkg::clock_waveform_offset) begin
                state_next.prdata = state_next.clock_waveform_settings;
            end else if (paddr == two_wire_pkg::receive_holding_offset) begin
                state_next.prdata[7:0] = state_next.receive_holding_reg;
            end
        end
    end

    // Single state register with asynchronous reset to constants.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '{
                scl_sync: 2'h3, sda_sync: 2'h3, scl_prev: 1'b1, sda_prev: 1'b1,
                phase: two_wire_pkg::st_idle, after_ack: two_wire_pkg::st_idle,
                transfer_complete_flag: 1'b1, transmit_ready_flag: 1'b1,
                default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

endmodule

// file: tb/bus_master_model.sv
// Behavioural two-wire bus master that pulls clock and data low.
// Assumes the bench forms each wire as a pulled-up line from all pull-down enables.
module bus_master_model (
    input  wire logic clk,
    input  wire logic scl_line,
    input  wire logic sda_line,
    output logic      scl_low = 1'b0,
    output logic      sda_low = 1'b0,
    output logic      hung = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int max_wait = 0;
    // Half a 200 ns bit period is four clock cycles.
    task automatic half();
        repeat (4) @(posedge clk);
    endtask
    // honour stretching: a bounded wait, so a stuck clock cannot hang the run.
    task automatic rise();
        int n;
        n = 0;
        scl_low <= 1'b0;
        @(posedge clk);
        while (!scl_line && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (n > max_wait) max_wait = n;
        hung <= (n >= 4000);
    endtask
    task automatic bit_io(input logic b, output logic got);
        sda_low <= !b;
        half();
        rise();
        repeat (2) @(posedge clk);
        got = sda_line;
        @(posedge clk);
        scl_low <= 1'b1;
    endtask
    // Works from idle and, as a repeated start, from a low clock.
    task automatic start_cond();
        sda_low <= 1'b0;
        half();
        rise();
        repeat (2) @(posedge clk);
        sda_low <= 1'b1;
        repeat (2) @(posedge clk);
        scl_low <= 1'b1;
    endtask
    // stop closes a transfer, also after a refused byte.
    task automatic stop_cond();
        sda_low <= 1'b1;
        half();
        rise();
        repeat (2) @(posedge clk);
        sda_low <= 1'b0;
        half();
    endtask
    task automatic byte_out(input logic [7:0] d, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], g);
        end
        bit_io(1'b1, g);
        ack = !g;
    endtask
    task automatic byte_in(input logic ack, output logic [7:0] d);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(!ack, g);
    endtask
endmodule

// file: tb/two_wire_slave_engine_monitor.sv
// Port checker for the two-wire slave engine.
// Assumes it is bound to the engine and sees only the engine's ports.
module two_wire_slave_engine_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        scl_in,
    input wire logic        scl_out,
    input wire logic        scl_oe,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Bus and pin relations
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_bus_zero_wait: assert property (pready && !pslverr)
        else $error("register slave stalled or flagged an error");
    a_open_drain_only: assert property (!scl_out && !sda_out)
        else $error("a bus pin is driven high");
    a_stretch_from_low: assert property ($rose(scl_oe) |-> !$past(scl_in))
        else $error("clock stretch began while the clock was high");
    a_stretch_keeps_low: assert property ($rose(scl_oe) |-> scl_oe [*2])
        else $error("clock stretch was a glitch");
    a_data_moves_low: assert property ($changed(sda_oe) |-> !$past(scl_in))
        else $error("data pin changed while the clock was high");
    a_data_steady_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data pin unstable in the clock high phase");
    a_ack_spans_bit: assert property ($rose(sda_oe) |-> sda_oe [*4])
        else $error("driven bit shorter than a clock phase");
    // Read data is only presented in the access cycle of a read.
    a_read_idle_zero: assert property (!$past(psel && !penable && !pwrite) |-> prdata == 32'h0)
        else $error("read data present without a read access");
endmodule
bind two_wire_slave_engine two_wire_slave_engine_monitor i_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

// file: tb/two_wire_slave_engine_test.sv
// Self-checking bench for the two-wire slave engine.
// Assumes the bus master model in the same folder and the engine's register package.
module two_wire_slave_engine_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0]  own_addr = 7'h2a;
    localparam logic [6:0]  new_addr = 7'h33;
    localparam logic [31:0] m_done   = 32'h1 << two_wire_pkg::transfer_complete_bit;
    localparam logic [31:0] m_rx     = 32'h1 << two_wire_pkg::receive_ready_bit;
    localparam logic [31:0] m_tx     = 32'h1 << two_wire_pkg::transmit_ready_bit;
    localparam logic [31:0] m_dir    = 32'h1 << two_wire_pkg::direction_bit;
    localparam logic [31:0] m_acc    = 32'h1 << two_wire_pkg::access_bit;
    localparam logic [31:0] m_gc     = 32'h1 << two_wire_pkg::general_call_bit;
    localparam logic [31:0] m_nack   = 32'h1 << two_wire_pkg::nack_bit;
    localparam logic [31:0] m_wait   = 32'h1 << two_wire_pkg::clock_wait_bit;
    localparam logic [31:0] m_end    = 32'h1 << two_wire_pkg::end_access_bit;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, scl_low, sda_low, hung, ack;
    logic [7:0]  rb;
    int          n_fail = 0, num_checks = 0;
    // Wired lines with pull-ups: low while any party pulls.
    wire scl_in = !(scl_oe || scl_low);
    wire sda_in = !(sda_oe || sda_low);
    always #12.5 pclk = ~pclk;
    two_wire_slave_engine i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
    bus_master_model i_master (.clk(pclk), .scl_line(scl_in), .sda_line(sda_in), .scl_low(scl_low),
        .sda_low(sda_low), .hung(hung));
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Read data stands in the access cycle and is taken at the edge that ends it.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 50) begin
            n_fail++;
            final_report();
        end
    endtask
    task automatic st_is(input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, two_wire_pkg::status_offset, 32'h0, rd);
        chk(rd & m, e);
    endtask
    task automatic t_setup();
        st_is(32'hffff_ffff, m_done | m_tx);
        apb(1'b0, 12'h0fc, 32'h0, rd);
        chk(rd, 32'h0);
        apb(1'b1, two_wire_pkg::slave_mode_offset, {9'h0, own_addr, 16'h0}, rd);
        apb(1'b1, two_wire_pkg::control_command_offset, 32'h1 << two_wire_pkg::master_disable_bit, rd);
        apb(1'b1, two_wire_pkg::control_command_offset, 32'h1 << two_wire_pkg::slave_enable_bit, rd);
        apb(1'b1, two_wire_pkg::clock_waveform_offset, 32'hffff_ffff, rd);
        apb(1'b1, two_wire_pkg::slave_mode_offset, {9'h0, 7'h11, 16'h0}, rd);
        i_master.start_cond();
        i_master.byte_out({7'h11, 1'b0}, ack);
        chk({31'h0, ack}, 32'h0);
        i_master.stop_cond();
        $display("test setup done");
    endtask
    task automatic t_write();
        i_master.start_cond();
        i_master.byte_out({own_addr, 1'b0}, ack);
        chk({31'h0, ack}, 32'h1);
        st_is(m_acc | m_dir, m_acc);
        i_master.byte_out(8'hc3, ack);
        st_is(m_rx, m_rx);
        apb(1'b0, two_wire_pkg::receive_holding_offset, 32'h0, rd);
        chk(rd, 32'hc3);
        st_is(m_rx, 32'h0);
        i_master.byte_out(8'h3c, ack);
        i_master.max_wait = 0;
        fork
            i_master.byte_out(8'h81, ack);
            begin
                repeat (300) @(posedge pclk);
                st_is(m_wait, m_wait);
                apb(1'b0, two_wire_pkg::receive_holding_offset, 32'h0, rd);
                chk(rd, 32'h3c);
            end
        join
        chk({31'h0, (i_master.max_wait > 100)}, 32'h1);
        st_is(m_wait, 32'h0);
        apb(1'b0, two_wire_pkg::receive_holding_offset, 32'h0, rd);
        chk(rd, 32'h81);
        i_master.stop_cond();
        st_is(m_done | m_acc | m_end, m_done | m_end);
        $display("test write done");
    endtask
    task automatic t_reversal();
        i_master.start_cond();
        i_master.byte_out({own_addr, 1'b0}, ack);
        i_master.byte_out(8'h77, ack);
        apb(1'b0, two_wire_pkg::receive_holding_offset, 32'h0, rd);
        chk(rd, 32'h77);
        fork
            begin
                i_master.start_cond();
                i_master.byte_out({own_addr, 1'b1}, ack);
            end
            begin
                repeat (300) @(posedge pclk);
                st_is(m_done | m_wait, m_wait);
                apb(1'b1, two_wire_pkg::transmit_holding_offset, 32'h5a, rd);
            end
        join
        chk({31'h0, ack}, 32'h1);
        st_is(m_acc | m_dir | m_done, m_acc | m_dir);
        i_master.byte_in(1'b1, rb);
        chk({24'h0, rb}, 32'h5a);
        st_is(m_tx, m_tx);
        apb(1'b1, two_wire_pkg::transmit_holding_offset, 32'h96, rd);
        st_is(m_tx, 32'h0);
        i_master.byte_in(1'b0, rb);
        chk({24'h0, rb}, 32'h96);
        st_is(m_nack | m_tx, m_nack | m_tx);
        i_master.stop_cond();
        st_is(m_done | m_acc | m_end, m_done | m_end);
        $display("test reversal done");
    endtask
    task automatic t_gcall();
        i_master.start_cond();
        i_master.byte_out(8'h00, ack);
        st_is(m_gc, m_gc);
        i_master.byte_out(8'h04, ack);
        apb(1'b0, two_wire_pkg::receive_holding_offset, 32'h0, rd);
        chk(rd, 32'h04);
        apb(1'b1, two_wire_pkg::slave_mode_offset, {9'h0, new_addr, 16'h0}, rd);
        i_master.stop_cond();
        i_master.start_cond();
        i_master.byte_out({new_addr, 1'b0}, ack);
        chk({31'h0, ack}, 32'h1);
        i_master.stop_cond();
        $display("test general call done");
    endtask
    // A stuck serial clock or a runaway run ends in the closing report.
    always @(posedge pclk) begin
        if (hung === 1'b1) begin
            n_fail++;
            final_report();
        end
    end
    initial begin
        repeat (100000) @(posedge pclk);
        n_fail++;
        final_report();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_setup();
        t_write();
        t_reversal();
        t_gcall();
        final_report();
    end
endmodule
